// File: src/dtw_pkg.sv
// package: constants and types for the three-wire command decoder and command set selector
package dtw_pkg;
    localparam int DI_WIDTH = 8;
    localparam int DI_SEL_W = 3;
    localparam int SET_MAX = 4;
    localparam int SET_IDX_W = 2;
    localparam int SETPT_W = 16;
    // interface presets that reroute the command sources
    localparam logic [7:0] PRESET_FIELDBUS_TERMINAL = 8'h07;
    localparam logic [7:0] PRESET_THREE_WIRE = 8'h14;
    // fixed terminal assignment of the three-wire preset
    localparam logic [2:0] PRESET_ENABLE_DI = 3'h0;
    localparam logic [2:0] PRESET_ON_DI = 3'h1;
    localparam logic [2:0] PRESET_DIR_DI = 3'h2;
    // commissioning states
    localparam logic [3:0] COMM_READY = 4'h0;
    localparam logic [3:0] COMM_DATA_SETS = 4'hF;
    // reset values
    localparam logic [2:0] SET_COUNT_RESET = 3'h2;
    localparam logic [1:0] ACTIVE_SET_RESET = 2'h0;
    // switchover time, about 4 ms at 100 MHz
    localparam int CLK_MHZ = 100;
    localparam int SWITCH_TIME_US = 4000;
    localparam int SWITCH_CYCLES = SWITCH_TIME_US * CLK_MHZ;
    localparam int SWITCH_CNT_W = 19;
    // motor direction
    typedef enum logic {DIR_CW = 1'b0, DIR_CCW = 1'b1} dtw_dir_t;
endpackage : dtw_pkg

// File: src/dtw_set_if.sv
// interface: command set selection request and result between decoder top and switchover timer
`timescale 1ns/1ns
interface dtw_set_if;
    logic [1:0] requested;
    logic [2:0] count;
    logic [1:0] active;
    logic busy;
    modport ctrl (output requested, output count, input active, input busy);
    modport timer (input requested, input count, output active, output busy);
endinterface : dtw_set_if

// File: src/dtw_set_switch.sv
// module: command set switchover timer, applies a new set selection after a settling delay
`timescale 1ns/1ns
module dtw_set_switch
    import dtw_pkg::*;
#(
    parameter int SWITCH_CYC = SWITCH_CYCLES
)(
    input wire logic clk_i,
    input wire logic rst_n_i,
    dtw_set_if.timer set_if
);
    initial
    begin
        if (SWITCH_CYC < 1 || SWITCH_CYC >= (1 << SWITCH_CNT_W))
            $error("switch delay out of range");
    end

    logic [SWITCH_CNT_W-1:0] cnt_reg;
    logic [1:0] active_reg;
    logic busy_reg;
    logic [1:0] limited;
    logic differs;

    // a selection beyond the configured count is clamped to the highest set
    assign limited = ({1'b0, set_if.requested} >= set_if.count) ? 2'(set_if.count - 3'h1) : set_if.requested;
    assign differs = (limited != active_reg);
    assign set_if.active = active_reg;
    assign set_if.busy = busy_reg;

    // restart the delay only when the target returns to the active set; a target that moves mid-delay is applied when the count ends
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_reg <= '0;
            active_reg <= ACTIVE_SET_RESET;
            busy_reg <= 1'b0;
        end
        else if (!differs)
        begin
            cnt_reg <= '0;
            busy_reg <= 1'b0;
        end
        else if (cnt_reg == SWITCH_CNT_W'(SWITCH_CYC - 1))
        begin
            active_reg <= limited;
            cnt_reg <= '0;
            busy_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_reg + 1'b1;
            busy_reg <= 1'b1;
        end
    end
endmodule : dtw_set_switch

// File: src/dtw_copy.sv
// module: command set storage with copy engine (one word per set, one cycle per copy)
`timescale 1ns/1ns
module dtw_copy
    import dtw_pkg::*;
#(
    parameter int WORD_W = 16
)(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire logic [1:0] wr_idx_i,
    input wire logic [WORD_W-1:0] wr_data_i,
    input wire logic start_i,
    input wire logic [1:0] src_i,
    input wire logic [1:0] dst_i,
    input wire logic [1:0] rd_idx_i,
    output logic [WORD_W-1:0] rd_data_o,
    output logic busy_o
);
    initial
    begin
        if (WORD_W < 1)
            $error("word width must be positive");
    end

    logic [WORD_W-1:0] mem [SET_MAX];
    logic busy_reg;
    logic [1:0] src_reg;
    logic [1:0] dst_reg;

    assign busy_o = busy_reg;
    assign rd_data_o = mem[rd_idx_i];

    // a start during a copy is ignored by this module; busy lasts exactly one cycle
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            busy_reg <= 1'b0;
            src_reg <= '0;
            dst_reg <= '0;
        end
        else if (start_i && !busy_reg)
        begin
            busy_reg <= 1'b1;
            src_reg <= src_i;
            dst_reg <= dst_i;
        end
        else
        begin
            busy_reg <= 1'b0;
        end
    end

    // storage: copy wins over a software write in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (busy_reg)
            mem[dst_reg] <= mem[src_reg];
        else if (wr_en_i)
            mem[wr_idx_i] <= wr_data_i;
    end
endmodule : dtw_copy

// File: src/dtw_top.sv
// top: three-wire start/stop decoder with command set selection, copy and setpoint routing
//
// Contract
// - enable low stops the motor by ramp, ignoring ON and direction.
// - with enable high, the motor starts only on a rising ON edge.
// - direction sampled at the ON edge: low clockwise, high counter-clockwise.
// - preset 20 takes enable, ON, direction from digital inputs 0, 1, 2.
// - three selectors pick each command's source from any digital input bit.
// - the set selection comes from any chosen control signal; here each selection bit is picked from a digital input bit only.
// - set switchover completes about 4 ms after the selection changes.
// - set count is two, three or four, two after reset.
// - above two sets, two selection bits choose the active set.
// - the active set index is readable.
// - copy source set to target on start, start clears when done.
// - preset 7: set 0 from fieldbus, set 1 from terminal strip.
// - main setpoint takes analog input 0 or 1.
`timescale 1ns/1ns
module dtw_top
    import dtw_pkg::*;
#(
    parameter int SWITCH_CYC = dtw_pkg::SWITCH_CYCLES,
    parameter int WORD_W = 16
)(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [dtw_pkg::DI_WIDTH-1:0] digital_input_i,
    input wire logic fieldbus_enable_i,
    input wire logic fieldbus_on_i,
    input wire logic fieldbus_dir_i,
    input wire logic [7:0] interface_preset_i,
    input wire logic [3:0] commissioning_state_i,
    input wire logic [2:0] wire_cmd1_source_i,
    input wire logic [2:0] wire_cmd2_source_i,
    input wire logic [2:0] wire_cmd3_source_i,
    input wire logic [2:0] command_set_select0_source_i,
    input wire logic [2:0] command_set_select1_source_i,
    input wire logic [2:0] command_set_count_i,
    input wire logic command_set_count_wr_i,
    input wire logic command_set_copy_start_i,
    input wire logic [1:0] command_set_copy_src_i,
    input wire logic [1:0] command_set_copy_dst_i,
    input wire logic set_data_wr_i,
    input wire logic [1:0] set_data_idx_i,
    input wire logic [WORD_W-1:0] set_data_i,
    input wire logic [dtw_pkg::SETPT_W-1:0] analog_input_value0_i,
    input wire logic [dtw_pkg::SETPT_W-1:0] analog_input_value1_i,
    input wire logic main_setpoint_source_i,
    output logic motor_on_o,
    output logic ramp_stop_o,
    output logic motor_dir_o,
    output logic [1:0] active_command_set_o,
    output logic [2:0] command_set_count_o,
    output logic command_set_copy_busy_o,
    output logic [WORD_W-1:0] active_set_data_o,
    output logic [dtw_pkg::SETPT_W-1:0] main_setpoint_o
);
    import dtw_pkg::*;

    initial
    begin
        if (DI_WIDTH > (1 << DI_SEL_W))
            $error("digital input count exceeds selector range");
    end

    // bit picker used by every routed source
    function automatic logic pick_di(input logic [DI_WIDTH-1:0] di, input logic [DI_SEL_W-1:0] sel);
        pick_di = di[sel];
    endfunction : pick_di

    ////////////////////////////////////////////////////////////////////////////
    // input synchroniser: terminals are asynchronous to clk_i
    logic [DI_WIDTH-1:0] di_meta_reg;
    logic [DI_WIDTH-1:0] di_sync_reg;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            di_meta_reg <= '0;
            di_sync_reg <= '0;
        end
        else
        begin
            di_meta_reg <= digital_input_i;
            di_sync_reg <= di_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command source routing
    logic preset_wired;
    logic [DI_SEL_W-1:0] sel_enable;
    logic [DI_SEL_W-1:0] sel_on;
    logic [DI_SEL_W-1:0] sel_dir;
    logic term_enable;
    logic term_on;
    logic term_dir;
    logic use_fieldbus;
    logic cmd_enable;
    logic cmd_on;
    logic cmd_dir;

    // the three-wire preset overrides the free selectors with fixed terminals
    assign preset_wired = (interface_preset_i == PRESET_THREE_WIRE);
    assign sel_enable = preset_wired ? PRESET_ENABLE_DI : wire_cmd1_source_i;
    assign sel_on = preset_wired ? PRESET_ON_DI : wire_cmd2_source_i;
    assign sel_dir = preset_wired ? PRESET_DIR_DI : wire_cmd3_source_i;
    assign term_enable = pick_di(di_sync_reg, sel_enable);
    assign term_on = pick_di(di_sync_reg, sel_on);
    assign term_dir = pick_di(di_sync_reg, sel_dir);

    // fieldbus commands only in set 0 of the fieldbus/terminal preset
    assign use_fieldbus = (interface_preset_i == PRESET_FIELDBUS_TERMINAL) &&
                          (active_command_set_o == 2'h0);
    assign cmd_enable = use_fieldbus ? fieldbus_enable_i : term_enable;
    assign cmd_on = use_fieldbus ? fieldbus_on_i : term_on;
    assign cmd_dir = use_fieldbus ? fieldbus_dir_i : term_dir;

    ////////////////////////////////////////////////////////////////////////////
    // three-wire start/stop decoder
    logic on_prev_reg;
    logic on_rise;
    logic motor_on_next;
    logic dir_next;

    assign on_rise = cmd_on && !on_prev_reg;
    // a level that is already high when enable returns is no edge, so the motor stays off
    assign motor_on_next = !cmd_enable ? 1'b0 : (on_rise ? 1'b1 : motor_on_o);
    assign dir_next = (cmd_enable && on_rise) ? cmd_dir : motor_dir_o;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            on_prev_reg <= 1'b0;
            motor_on_o <= 1'b0;
            ramp_stop_o <= 1'b1;
            motor_dir_o <= DIR_CW;
        end
        else
        begin
            on_prev_reg <= cmd_on;
            motor_on_o <= motor_on_next;
            ramp_stop_o <= !motor_on_next;
            motor_dir_o <= dir_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command set count, writable only in commissioning state
    logic count_ok;
    logic count_wr;

    assign count_ok = (command_set_count_i >= 3'h2) && (command_set_count_i <= 3'h4);
    assign count_wr = command_set_count_wr_i && count_ok &&
                      (commissioning_state_i == COMM_DATA_SETS);

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            command_set_count_o <= SET_COUNT_RESET;
        else if (count_wr)
            command_set_count_o <= command_set_count_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // command set selection and switchover
    dtw_set_if set_if ();
    logic sel_bit0;
    logic sel_bit1;

    assign sel_bit0 = pick_di(di_sync_reg, command_set_select0_source_i);
    // bit 1 only matters when more than two sets exist
    assign sel_bit1 = (command_set_count_o > 3'h2) &&
                      pick_di(di_sync_reg, command_set_select1_source_i);
    assign set_if.requested = {sel_bit1, sel_bit0};
    assign set_if.count = command_set_count_o;

    dtw_set_switch #(
        .SWITCH_CYC(SWITCH_CYC)
    ) u_switch (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .set_if(set_if)
    );

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            active_command_set_o <= ACTIVE_SET_RESET;
        else
            active_command_set_o <= set_if.active;
    end

    ////////////////////////////////////////////////////////////////////////////
    // command set copy: busy stands for the start field, cleared when done
    logic copy_busy;
    logic [WORD_W-1:0] set_word;

    dtw_copy #(
        .WORD_W(WORD_W)
    ) u_copy (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(set_data_wr_i),
        .wr_idx_i(set_data_idx_i),
        .wr_data_i(set_data_i),
        .start_i(command_set_copy_start_i),
        .src_i(command_set_copy_src_i),
        .dst_i(command_set_copy_dst_i),
        .rd_idx_i(set_if.active),
        .rd_data_o(set_word),
        .busy_o(copy_busy)
    );

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            command_set_copy_busy_o <= 1'b0;
            active_set_data_o <= '0;
        end
        else
        begin
            command_set_copy_busy_o <= copy_busy;
            active_set_data_o <= set_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // main setpoint from analog input 0 or 1
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            main_setpoint_o <= '0;
        else
            main_setpoint_o <= main_setpoint_source_i ? analog_input_value1_i : analog_input_value0_i;
    end
endmodule : dtw_top

// File: dv/dtw_ctrl_box.sv
// partner: controller that commissions the decoder (preset and set count)
`timescale 1ns/1ns
module dtw_ctrl_box
    import dtw_pkg::*;
(
    input wire logic clk_i,
    output logic [7:0] interface_preset_o,
    output logic [3:0] commissioning_state_o,
    output logic [2:0] command_set_count_o,
    output logic command_set_count_wr_o
);
    //////////////////////////////////////////////////////////////////////////
    // idle: ready state, terminal preset, no write pending
    initial
    begin
        interface_preset_o = 8'h00;
        commissioning_state_o = COMM_READY;
        command_set_count_o = SET_COUNT_RESET;
        command_set_count_wr_o = 1'b0;
    end
    // a preset change is always made inside a commissioning pass, state 15 before and ready after
    task automatic load_preset(input logic [7:0] p);
        @(posedge clk_i) commissioning_state_o <= COMM_DATA_SETS;
        @(posedge clk_i) interface_preset_o <= p;
        @(posedge clk_i) commissioning_state_o <= COMM_READY;
    endtask : load_preset
    // skip_comm leaves out state 15 on purpose, so the write must be refused
    task automatic load_count(input logic [2:0] n, input logic skip_comm);
        @(posedge clk_i) commissioning_state_o <= skip_comm ? COMM_READY : COMM_DATA_SETS;
        @(posedge clk_i) command_set_count_o <= n;
        command_set_count_wr_o <= 1'b1;
        @(posedge clk_i) command_set_count_wr_o <= 1'b0;
        @(posedge clk_i) commissioning_state_o <= COMM_READY;
    endtask : load_count
endmodule : dtw_ctrl_box

// File: dv/dtw_top_sva.sv
// checker: port assertions for the decoder top
`timescale 1ns/1ns
module dtw_top_sva
    import dtw_pkg::*;
#(
    parameter int SWITCH_CYC = 8
)(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic fieldbus_enable_i,
    input wire logic fieldbus_on_i,
    input wire logic fieldbus_dir_i,
    input wire logic [7:0] interface_preset_i,
    input wire logic [3:0] commissioning_state_i,
    input wire logic [2:0] command_set_count_i,
    input wire logic command_set_count_wr_i,
    input wire logic command_set_copy_start_i,
    input wire logic [SETPT_W-1:0] analog_input_value1_i,
    input wire logic main_setpoint_source_i,
    input wire logic motor_on_o,
    input wire logic ramp_stop_o,
    input wire logic motor_dir_o,
    input wire logic [1:0] active_command_set_o,
    input wire logic [2:0] command_set_count_o,
    input wire logic command_set_copy_busy_o,
    input wire logic [SETPT_W-1:0] main_setpoint_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    //////////////////////////////////////////////////////////////////////////
    // fieldbus owns the commands only in preset 7 with set 0 active
    wire fb_mode = interface_preset_i == PRESET_FIELDBUS_TERMINAL && active_command_set_o == 2'h0;
    // cycles since the active set last moved; 32 bits never wrap in a run
    logic [31:0] gap_reg;
    always_ff @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
            gap_reg <= 32'h0;
        else
            gap_reg <= $changed(active_command_set_o) ? 32'h0 : gap_reg + 32'h1;
    //////////////////////////////////////////////////////////////////////////
    chk_stop_on_low: assert property (fb_mode && !fieldbus_enable_i |=> !motor_on_o)
        else $error("motor runs with enable low");
    chk_ramp_mirror: assert property (ramp_stop_o == !motor_on_o)
        else $error("ramp stop not inverse of run");
    chk_start_edge: assert property ($rose(motor_on_o) && $past(fb_mode)
        |-> $past(fieldbus_on_i) && !$past(fieldbus_on_i, 2))
        else $error("motor started without on edge");
    chk_dir_at_start: assert property ($rose(motor_on_o) && $past(fb_mode)
        |-> motor_dir_o == $past(fieldbus_dir_i))
        else $error("direction not taken at on edge");
    chk_count_legal: assert property (command_set_count_o inside {3'h2, 3'h3, 3'h4})
        else $error("set count out of range");
    chk_count_guard: assert property ($changed(command_set_count_o) |-> $past(command_set_count_wr_i)
        && $past(commissioning_state_i) == COMM_DATA_SETS && $past(command_set_count_i) == command_set_count_o)
        else $error("set count changed outside state 15");
    chk_set_in_range: assert property ({1'b0, active_command_set_o} < command_set_count_o)
        else $error("active set above count");
    chk_switch_time: assert property ($changed(active_command_set_o) |-> gap_reg >= SWITCH_CYC)
        else $error("set switched too fast");
    chk_copy_done: assert property ($rose(command_set_copy_start_i) && !command_set_copy_busy_o
        |-> ##[1:2] command_set_copy_busy_o ##1 !command_set_copy_busy_o)
        else $error("copy start field not cleared");
    chk_setpoint_one: assert property (main_setpoint_source_i |=> main_setpoint_o == $past(analog_input_value1_i))
        else $error("setpoint not from analog input 1");
endmodule : dtw_top_sva

bind dtw_top dtw_top_sva #(.SWITCH_CYC(SWITCH_CYC)) i_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .fieldbus_enable_i(fieldbus_enable_i), .fieldbus_on_i(fieldbus_on_i), .fieldbus_dir_i(fieldbus_dir_i),
    .interface_preset_i(interface_preset_i), .commissioning_state_i(commissioning_state_i),
    .command_set_count_i(command_set_count_i), .command_set_count_wr_i(command_set_count_wr_i),
    .command_set_copy_start_i(command_set_copy_start_i), .analog_input_value1_i(analog_input_value1_i),
    .main_setpoint_source_i(main_setpoint_source_i), .motor_on_o(motor_on_o), .ramp_stop_o(ramp_stop_o),
    .motor_dir_o(motor_dir_o), .active_command_set_o(active_command_set_o),
    .command_set_count_o(command_set_count_o), .command_set_copy_busy_o(command_set_copy_busy_o),
    .main_setpoint_o(main_setpoint_o));

// File: dv/dtw_top_tb.sv
// testbench: drives the decoder top and checks outputs against noted expectations
`timescale 1ns/1ns
module dtw_top_tb;
    import dtw_pkg::*;
    localparam int SW = 8;
    typedef struct packed {logic [2:0] sel; logic [15:0] val;} dtw_note_t;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] di = 8'h00;
    logic fb_en = 1'b0, fb_on = 1'b0, fb_dir = 1'b0, cp_go = 1'b0, dwr = 1'b0, sp_src = 1'b0;
    logic [2:0] src1 = 3'h0, src2 = 3'h1, src3 = 3'h2, sel0 = 3'h3, sel1 = 3'h4;
    logic [1:0] cp_src = 2'h0, cp_dst = 2'h0, didx = 2'h0, act;
    logic [15:0] ddata = 16'h0, a0 = 16'h0, a1 = 16'h0, sdata, spt;
    logic [7:0] preset;
    logic [3:0] comm;
    logic [2:0] cnt_in, cnt_out;
    logic cnt_wr, run, stop, dir, busy;
    dtw_note_t note_q[$];
    int fail_count = 0;
    int comparisons = 0;
    event look;
    always #5 clk_i = ~clk_i;
    //////////////////////////////////////////////////////////////////////////
    dtw_ctrl_box i_box (.clk_i(clk_i), .interface_preset_o(preset), .commissioning_state_o(comm),
        .command_set_count_o(cnt_in), .command_set_count_wr_o(cnt_wr));
    // short switchover count keeps the run small
    dtw_top #(.SWITCH_CYC(SW), .WORD_W(16)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .digital_input_i(di),
        .fieldbus_enable_i(fb_en), .fieldbus_on_i(fb_on), .fieldbus_dir_i(fb_dir), .interface_preset_i(preset),
        .commissioning_state_i(comm), .wire_cmd1_source_i(src1), .wire_cmd2_source_i(src2),
        .wire_cmd3_source_i(src3), .command_set_select0_source_i(sel0), .command_set_select1_source_i(sel1),
        .command_set_count_i(cnt_in), .command_set_count_wr_i(cnt_wr), .command_set_copy_start_i(cp_go),
        .command_set_copy_src_i(cp_src), .command_set_copy_dst_i(cp_dst), .set_data_wr_i(dwr),
        .set_data_idx_i(didx), .set_data_i(ddata), .analog_input_value0_i(a0), .analog_input_value1_i(a1),
        .main_setpoint_source_i(sp_src), .motor_on_o(run), .ramp_stop_o(stop), .motor_dir_o(dir),
        .active_command_set_o(act), .command_set_count_o(cnt_out), .command_set_copy_busy_o(busy),
        .active_set_data_o(sdata), .main_setpoint_o(spt));
    //////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [15:0] pick(input logic [2:0] s);
        case (s)
            3'h0: return {15'h0, run};
            3'h1: return {15'h0, dir};
            3'h2: return {14'h0, act};
            3'h3: return {13'h0, cnt_out};
            3'h4: return sdata;
            3'h5: return spt;
            3'h6: return {15'h0, busy};
            default: return {15'h0, stop};
        endcase
    endfunction : pick
    // notes an expectation, then looks d edges later at the settled negedge
    task automatic note(input logic [2:0] s, input logic [15:0] v, input int d);
        note_q.push_back('{s, v});
        repeat (d) @(posedge clk_i);
        @(negedge clk_i);
        -> look;
    endtask : note
    task automatic fb(input logic e, input logic o, input logic d);
        @(posedge clk_i);
        fb_en <= e;
        fb_on <= o;
        fb_dir <= d;
    endtask : fb
    task automatic di_set(input logic [7:0] v);
        @(posedge clk_i);
        di <= v;
    endtask : di_set
    task automatic give_verdict();
        $display("counts: %0d compared, %0d wrong", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    // monitor: oldest note against the output it names
    always @(look)
    begin
        check(pick(note_q[0].sel), note_q[0].val);
        void'(note_q.pop_front());
    end
    //////////////////////////////////////////////////////////////////////////
    initial
    begin : main
        logic [15:0] w [4];
        void'($urandom(32'hE806));
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        note(3'h3, 16'h2, 1);
        note(3'h2, 16'h0, 0);
        note(3'h0, 16'h0, 0);
        note(3'h7, 16'h1, 0);
        $display("reset test done");
        // on rises while enable is low, so enable alone must not start
        i_box.load_preset(PRESET_FIELDBUS_TERMINAL);
        fb(1'b0, 1'b1, 1'b0);
        note(3'h0, 16'h0, 2);
        fb(1'b1, 1'b1, 1'b0);
        note(3'h0, 16'h0, 2);
        for (int k = 0; k < 2; k++)
        begin
            fb(1'b1, 1'b0, k[0]);
            fb(1'b1, 1'b1, k[0]);
            note(3'h0, 16'h1, 2);
            note(3'h1, {15'h0, k[0]}, 0);
            note(3'h7, 16'h0, 0);
            fb(1'b0, 1'b1, ~k[0]);
            note(3'h0, 16'h0, 2);
            fb(1'b1, 1'b1, ~k[0]);
            note(3'h0, 16'h0, 2);
        end
        // preset 20 must ignore the selectors, preset 0 must honour them
        i_box.load_preset(PRESET_THREE_WIRE);
        @(posedge clk_i);
        src1 <= 3'h7;
        src2 <= 3'h6;
        src3 <= 3'h5;
        di_set(8'h05);
        di_set(8'h07);
        note(3'h0, 16'h1, 4);
        note(3'h1, 16'h1, 0);
        di_set(8'h06);
        note(3'h0, 16'h0, 4);
        i_box.load_preset(8'h00);
        di_set(8'h80);
        di_set(8'hC0);
        note(3'h0, 16'h1, 4);
        note(3'h1, 16'h0, 0);
        $display("command source tests done");
        i_box.load_count(3'h4, 1'b1);
        note(3'h3, 16'h2, 1);
        i_box.load_count(3'h5, 1'b0);
        note(3'h3, 16'h2, 1);
        i_box.load_count(3'h3, 1'b0);
        note(3'h3, 16'h3, 1);
        i_box.load_count(3'h4, 1'b0);
        note(3'h3, 16'h4, 1);
        di_set(8'hD8);
        note(3'h2, 16'h0, 4);
        note(3'h2, 16'h3, SW + 4);
        for (int k = 0; k < 4; k++)
        begin
            w[k] = 16'($urandom);
            @(posedge clk_i);
            dwr <= 1'b1;
            didx <= 2'(k);
            ddata <= w[k];
        end
        @(posedge clk_i);
        dwr <= 1'b0;
        note(3'h4, w[3], 2);
        @(posedge clk_i);
        cp_go <= 1'b1;
        cp_src <= 2'h2;
        cp_dst <= 2'h3;
        @(posedge clk_i);
        cp_go <= 1'b0;
        note(3'h6, 16'h1, 1);
        note(3'h6, 16'h0, 0);
        note(3'h4, w[2], 1);
        $display("set tests done");
        // set 1 under preset 7 listens to the terminals, not the fieldbus
        di_set(8'hC8);
        note(3'h2, 16'h1, SW + 8);
        i_box.load_preset(PRESET_FIELDBUS_TERMINAL);
        fb(1'b0, 1'b0, 1'b0);
        note(3'h0, 16'h1, 2);
        di_set(8'h48);
        note(3'h0, 16'h0, 4);
        for (int k = 0; k < 2; k++)
        begin
            w[0] = 16'($urandom);
            w[1] = 16'($urandom);
            @(posedge clk_i);
            a0 <= w[0];
            a1 <= w[1];
            sp_src <= k[0];
            note(3'h5, w[k], 1);
        end
        $display("setpoint test done");
        give_verdict();
    end
    // watchdog: the tests need well under a thousand cycles
    initial
    begin
        #100000;
        fail_count++;
        give_verdict();
    end
endmodule : dtw_top_tb
